// ### aexp_pkg.sv
// ==========================================================================
// Shared constants for the expansion status block
package aexp_pkg;

   // ==========================================================================
   // Register indices and byte addresses (byte address = index * 4)
   localparam logic [7:0]  IDX_LPA     = 8'h05;
   localparam logic [7:0]  IDX_EXP     = 8'h06;
   localparam logic [7:0]  IDX_CTRL    = 8'h10;
   localparam logic [7:0]  IDX_IRQ_STS = 8'h20;
   localparam logic [7:0]  IDX_IRQ_CLR = 8'h21;
   localparam logic [7:0]  IDX_IRQ_EN  = 8'h22;
   localparam logic [7:0]  ADDR_LPA     = {IDX_LPA[5:0], 2'b00};
   localparam logic [7:0]  ADDR_EXP     = {IDX_EXP[5:0], 2'b00};
   localparam logic [7:0]  ADDR_CTRL    = {IDX_CTRL[5:0], 2'b00};
   localparam logic [7:0]  ADDR_IRQ_STS = {IDX_IRQ_STS[5:0], 2'b00};
   localparam logic [7:0]  ADDR_IRQ_CLR = {IDX_IRQ_CLR[5:0], 2'b00};
   localparam logic [7:0]  ADDR_IRQ_EN  = {IDX_IRQ_EN[5:0], 2'b00};

   // ==========================================================================
   // Expansion register fields
   localparam int          RSV_MSB  = 15;
   localparam int          RSV_LSB  = 5;
   localparam int          B_PDF    = 4;
   localparam int          B_LPNP   = 3;
   localparam int          B_NPA    = 2;
   localparam int          B_PGRX   = 1;
   localparam int          B_LPAN   = 0;
   localparam int          B_LCW_NP = 15;
   localparam logic [15:0] EXP_RST  = 16'h0004;
   localparam logic [10:0] RSV_RST  = 11'h000;

   // ==========================================================================
   // Control and interrupt fields
   localparam int          B_OVR    = 15;
   localparam int          I_PDF    = 0;
   localparam int          I_PGRX   = 1;
   localparam int          I_LPAN   = 2;
   localparam int          IRQ_W    = 3;
   localparam logic [2:0]  IRQ_RST  = 3'h0;
   localparam logic [15:0] LPA_RST  = 16'h0000;
   localparam logic [1:0]  RESP_OK  = 2'b00;
   localparam logic [1:0]  RESP_ERR = 2'b10;

endpackage : aexp_pkg

// ### aexp_lh_bit.sv
`timescale 1ns/100ps
// ==========================================================================
// Sticky bit: set wins over clear, resets to zero
module aexp_lh_bit
(
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);
   logic q_next;

   // Set beats a clear in the same cycle so no event is lost
   always_comb
   begin
      q_next = set | (q & ~clr);
   end

   // Register
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         q <= 1'b0;
      else
         q <= q_next;
   end
endmodule : aexp_lh_bit

// ### aexp_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Reserved bits fifteen to five always read back as zero.
// - Reserved bit writes take effect only while the override bit is set.
// - Parallel detection fault bit sets when partner technology is ambiguous.
// - Parallel detection fault bit latches high once seen.
// - Partner next-page bit follows next-page bit of received control word.
// - Local next-page capability reads as constant one, also after reset.
// - Page received sets whenever a new control word is stored.
// - Reading the expansion register clears page received.
// - Partner autonegotiation bit sets on a valid pulse burst and stays set until reset.
// - Partner ability register loads from each received control word.
module aexp_top
   import aexp_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        an_par_fault,
   input  wire logic        an_lcw_stb,
   input  wire logic [15:0] an_lcw_word,
   input  wire logic        an_flp_ok,
   output logic [10:0]      rsv_aux,
   output logic             irq
);

   // ==========================================================================
   // Declarations
   logic [7:0]  aw_addr_reg, aw_addr_next;
   logic        aw_have_reg, aw_have_next;
   logic [15:0] w_data_reg, w_data_next;
   logic [1:0]  w_strb_reg, w_strb_next;
   logic        w_have_reg, w_have_next;
   logic        awready_reg, awready_next;
   logic        wready_reg, wready_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        arready_reg, arready_next;
   logic        rvalid_reg, rvalid_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [10:0] rsv_reg, rsv_next;
   logic        ovr_reg, ovr_next;
   logic [15:0] lpa_reg, lpa_next;
   logic        lp_np_reg, lp_np_next;
   logic        lp_an_reg, lp_an_next;
   logic [2:0]  irq_en_reg, irq_en_next;
   logic        irq_reg, irq_next;
   logic        wr_do;
   logic        rd_take;
   logic        rd_exp;
   logic        wr_hit;
   logic [15:0] wr_mask;
   logic        pdf_q;
   logic        pgrx_q;
   logic [2:0]  irq_sts;
   logic [2:0]  irq_set;
   logic [2:0]  irq_clr;
   logic [15:0] exp_view;

   // ==========================================================================
   // Bus handshakes
   assign wr_do   = aw_have_reg & w_have_reg & ~bvalid_reg;
   assign rd_take = s_axi_arvalid & arready_reg;
   assign rd_exp  = rd_take & (s_axi_araddr == ADDR_EXP);
   assign wr_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

   // Decode of the write address, used for the response code
   always_comb
   begin
      case (aw_addr_reg)
         ADDR_LPA, ADDR_EXP, ADDR_CTRL, ADDR_IRQ_STS, ADDR_IRQ_CLR, ADDR_IRQ_EN:
            wr_hit = 1'b1;
         default:
            wr_hit = 1'b0;
      endcase
   end

   // Write channels: address and data caught in either order
   always_comb
   begin
      aw_addr_next = aw_addr_reg;
      aw_have_next = aw_have_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      w_have_next  = w_have_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      if (s_axi_awvalid & awready_reg)
      begin
         aw_addr_next = s_axi_awaddr;
         aw_have_next = 1'b1;
      end
      if (s_axi_wvalid & wready_reg)
      begin
         w_data_next = s_axi_wdata[15:0];
         w_strb_next = s_axi_wstrb[1:0];
         w_have_next = 1'b1;
      end
      if (wr_do)
      begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_hit ? RESP_OK : RESP_ERR;
      end
      else if (bvalid_reg & s_axi_bready)
      begin
         bvalid_next = 1'b0;
      end
      // Ready only while the holding slot is free
      awready_next = ~aw_have_next;
      wready_next  = ~w_have_next;
   end

   // Register writes; reserved and read-only bits of other registers ignore
   always_comb
   begin
      rsv_next    = rsv_reg;
      ovr_next    = ovr_reg;
      irq_en_next = irq_en_reg;
      irq_clr     = IRQ_RST;
      if (wr_do)
      begin
         case (aw_addr_reg)
            ADDR_EXP:
            begin
               if (ovr_reg)
                  rsv_next = (rsv_reg & ~wr_mask[RSV_MSB:RSV_LSB])
                           | (w_data_reg[RSV_MSB:RSV_LSB] & wr_mask[RSV_MSB:RSV_LSB]);
            end
            ADDR_CTRL:
               if (w_strb_reg[1])
                  ovr_next = w_data_reg[B_OVR];
            ADDR_IRQ_CLR:
               if (w_strb_reg[0])
                  irq_clr = w_data_reg[IRQ_W-1:0];
            ADDR_IRQ_EN:
               if (w_strb_reg[0])
                  irq_en_next = w_data_reg[IRQ_W-1:0];
            default:
               ;
         endcase
      end
   end

   // ==========================================================================
   // Auto-negotiation status
   always_comb
   begin
      lpa_next   = lpa_reg;
      lp_np_next = lp_np_reg;
      lp_an_next = lp_an_reg;
      if (an_lcw_stb)
         lpa_next = an_lcw_word;
      if (an_lcw_stb)
         lp_np_next = an_lcw_word[B_LCW_NP];
      if (an_flp_ok)
         lp_an_next = 1'b1;
   end

   // latched until read, read clears only once condition gone
   aexp_lh_bit u_pdf
   (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .set     (an_par_fault),
      .clr     (rd_exp),
      .q       (pdf_q)
   );

   // stored control word raises page received
   // read of the expansion register clears it
   aexp_lh_bit u_pgrx
   (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .set     (an_lcw_stb),
      .clr     (rd_exp),
      .q       (pgrx_q)
   );

   always_comb
   begin
      exp_view         = EXP_RST;
      exp_view[B_PDF]  = pdf_q;
      exp_view[B_LPNP] = lp_np_reg;
      exp_view[B_PGRX] = pgrx_q;
      exp_view[B_LPAN] = lp_an_reg;
   end

   // ==========================================================================
   // Interrupt status: event sets win over software clears
   assign irq_set[I_PDF]  = an_par_fault & ~pdf_q;
   assign irq_set[I_PGRX] = an_lcw_stb;
   assign irq_set[I_LPAN] = an_flp_ok & ~lp_an_reg;

   generate
      for (genvar i = 0; i < IRQ_W; i++)
      begin : g_irq
         aexp_lh_bit u_sts
         (
            .mclk    (mclk),
            .sys_rst (sys_rst),
            .set     (irq_set[i]),
            .clr     (irq_clr[i]),
            .q       (irq_sts[i])
         );
      end
   endgenerate

   // One cycle behind the status bits, kept registered for a clean output
   always_comb
   begin
      irq_next = |(irq_sts & irq_en_reg);
   end

   // ==========================================================================
   // Read channel; the read value is taken before the side-effect clear
   always_comb
   begin
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (rd_take)
      begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OK;
         case (s_axi_araddr)
            ADDR_LPA:     rdata_next = lpa_reg;
            ADDR_EXP:     rdata_next = exp_view;
            ADDR_CTRL:    rdata_next = {ovr_reg, 15'h0000};
            ADDR_IRQ_STS: rdata_next = {13'h0000, irq_sts};
            ADDR_IRQ_CLR: rdata_next = 16'h0000;
            ADDR_IRQ_EN:  rdata_next = {13'h0000, irq_en_reg};
            default:
            begin
               rdata_next = 16'h0000;
               rresp_next = RESP_ERR;
            end
         endcase
      end
      else if (rvalid_reg & s_axi_rready)
      begin
         rvalid_next = 1'b0;
      end
      arready_next = ~rvalid_next;
   end

   // ==========================================================================
   // registers, reset values
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         aw_addr_reg <= 8'h00;
         aw_have_reg <= 1'b0;
         w_data_reg  <= 16'h0000;
         w_strb_reg  <= 2'b00;
         w_have_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OK;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OK;
         rdata_reg   <= 16'h0000;
         rsv_reg     <= RSV_RST;
         ovr_reg     <= 1'b0;
         lpa_reg     <= LPA_RST;
         lp_np_reg   <= 1'b0;
         lp_an_reg   <= 1'b0;
         irq_en_reg  <= IRQ_RST;
         irq_reg     <= 1'b0;
      end
      else
      begin
         aw_addr_reg <= aw_addr_next;
         aw_have_reg <= aw_have_next;
         w_data_reg  <= w_data_next;
         w_strb_reg  <= w_strb_next;
         w_have_reg  <= w_have_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
         rsv_reg     <= rsv_next;
         ovr_reg     <= ovr_next;
         lpa_reg     <= lpa_next;
         lp_np_reg   <= lp_np_next;
         lp_an_reg   <= lp_an_next;
         irq_en_reg  <= irq_en_next;
         irq_reg     <= irq_next;
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = {16'h0000, rdata_reg};
   assign rsv_aux       = rsv_reg;
   assign irq           = irq_reg;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_rsv_zero;
      rd_exp |=> (s_axi_rdata[15:5] == 11'h000) && s_axi_rvalid;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved bits not zero on read");

   property p_ovr_gate;
      (wr_do && aw_addr_reg == ADDR_EXP && !ovr_reg) |=> $stable(rsv_reg);
   endproperty
   a_ovr_gate: assert property (p_ovr_gate)
      else $error("reserved bits changed without override");

   property p_ovr_write;
      (wr_do && aw_addr_reg == ADDR_EXP && ovr_reg && w_strb_reg == 2'b11)
         |=> rsv_reg == $past(w_data_reg[15:5]);
   endproperty
   a_ovr_write: assert property (p_ovr_write)
      else $error("override write not applied");

   property p_pdf_set;
      an_par_fault |=> pdf_q ##1 (pdf_q || $past(rd_exp));
   endproperty
   a_pdf_set: assert property (p_pdf_set)
      else $error("fault bit not set");

   property p_pdf_hold;
      (pdf_q && !rd_exp) |=> pdf_q;
   endproperty
   a_pdf_hold: assert property (p_pdf_hold)
      else $error("fault bit dropped before read");

   property p_lp_np;
      an_lcw_stb |=> lp_np_reg == $past(an_lcw_word[15]);
   endproperty
   a_lp_np: assert property (p_lp_np)
      else $error("partner next-page bit wrong");

   property p_npa_one;
      rd_exp |=> s_axi_rdata[2];
   endproperty
   a_npa_one: assert property (p_npa_one)
      else $error("local next-page bit not one");

   property p_pgrx_set;
      an_lcw_stb |=> pgrx_q && lpa_reg == $past(an_lcw_word);
   endproperty
   a_pgrx_set: assert property (p_pgrx_set)
      else $error("page received or store missing");

   property p_pgrx_clr;
      (rd_exp && !an_lcw_stb) |=> !pgrx_q && s_axi_rdata[1] == $past(pgrx_q);
   endproperty
   a_pgrx_clr: assert property (p_pgrx_clr)
      else $error("page received not cleared by read");

   property p_lpan;
      an_flp_ok |=> lp_an_reg [*2];
   endproperty
   a_lpan: assert property (p_lpan)
      else $error("partner negotiation bit not set");

   property p_lh_hold;
      (pgrx_q && !rd_exp) |=> pgrx_q;
   endproperty
   a_lh_hold: assert property (p_lh_hold)
      else $error("latched bit lost before read");

   property p_rst_val;
      $fell(sys_rst) |-> exp_view == EXP_RST;
   endproperty
   a_rst_val: assert property (p_rst_val)
      else $error("expansion reset value wrong");

endmodule : aexp_top

// ### aexp_link_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Far side: auto-negotiation engine that feeds link events
module aexp_link_model
(
   input  wire logic        mclk,
   output logic             an_par_fault,
   output logic             an_lcw_stb,
   output logic [15:0]      an_lcw_word,
   output logic             an_flp_ok
);
   // Quiet link at time zero
   initial
   begin
      an_par_fault = 1'b0;
      an_lcw_stb   = 1'b0;
      an_lcw_word  = 16'h5a5a;
      an_flp_ok    = 1'b0;
   end

   task automatic send_word(input logic [15:0] w);
      @(posedge mclk);
      an_lcw_stb  <= 1'b1;
      an_lcw_word <= w;
      @(posedge mclk);
      an_lcw_stb  <= 1'b0;
      // Stale word shown inverted so nothing relies on it
      an_lcw_word <= ~w;
   endtask : send_word

   // Fault condition is a level
   task automatic set_fault(input logic on);
      @(posedge mclk);
      an_par_fault <= on;
   endtask : set_fault

   // One valid burst seen
   task automatic flp_burst();
      @(posedge mclk);
      an_flp_ok <= 1'b1;
      @(posedge mclk);
      an_flp_ok <= 1'b0;
   endtask : flp_burst
endmodule : aexp_link_model

// ### aexp_top_bench.sv
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("mismatch at %0t: %s", $time, msg); end end
// ==========================================================================
// Bench for the expansion status block
module aexp_top_bench
   import aexp_pkg::*;
;
   logic        mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb;
   logic [10:0] rsv_aux;
   logic        flt, stb, flp;
   logic [15:0] word;
   int          n_errors, num_checks, cyc;

   aexp_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .an_par_fault(flt), .an_lcw_stb(stb),
      .an_lcw_word(word), .an_flp_ok(flp), .rsv_aux(rsv_aux), .irq(irq));
   aexp_link_model i_link (.mclk(mclk), .an_par_fault(flt), .an_lcw_stb(stb),
      .an_lcw_word(word), .an_flp_ok(flp));

   // ==========================================================================
   // Clock and hang guard
   always #20 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc++;
      // Tests need well under a thousand cycles
      if (cyc == 5000)
      begin
         n_errors++;
         $display("mismatch at %0t: timeout", $time);
         conclude();
      end
   end

   // ==========================================================================
   // Bus tasks: hold each channel until its own ready
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever
      begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            bready <= 1'b0;
            `CHK(bresp, er, "write response")
            break;
         end
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever
      begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            rready <= 1'b0;
            `CHK(rdata, {16'h0000, e}, "read data")
            `CHK(rresp, er, "read response")
            break;
         end
      end
   endtask : rd

   // ==========================================================================
   // Scenarios
   task automatic t_reserved();
      // Override clear: reserved write must not land
      wr(ADDR_EXP, 16'hffe0, RESP_OK);
      `CHK(rsv_aux, 11'h000, "write isolated")
      rd(ADDR_EXP, 16'h0004, RESP_OK);
      wr(ADDR_CTRL, 16'h8000, RESP_OK);
      // Low byte lane only: bits 15:8 must keep their value
      wstrb <= 4'h1;
      wr(ADDR_EXP, 16'hffe0, RESP_OK);
      `CHK(rsv_aux, 11'h007, "low lane only")
      wstrb <= 4'hf;
      wr(ADDR_EXP, 16'hffe0, RESP_OK);
      `CHK(rsv_aux, 11'h7ff, "override write")
      rd(ADDR_EXP, 16'h0004, RESP_OK);
      wr(ADDR_EXP, {RSV_RST, 5'h00}, RESP_OK);
      `CHK(rsv_aux, 11'h000, "defaults back")
      wr(ADDR_CTRL, 16'h0000, RESP_OK);
      $display("test reserved done");
   endtask : t_reserved

   task automatic t_page();
      i_link.send_word(16'h8001);
      rd(ADDR_LPA, 16'h8001, RESP_OK);
      rd(ADDR_EXP, 16'h000e, RESP_OK);
      rd(ADDR_EXP, 16'h000c, RESP_OK);
      i_link.send_word(16'h0001);
      rd(ADDR_EXP, 16'h0006, RESP_OK);
      rd(ADDR_EXP, 16'h0004, RESP_OK);
      $display("test page done");
   endtask : t_page

   task automatic t_fault();
      i_link.set_fault(1'b1);
      i_link.set_fault(1'b0);
      rd(ADDR_EXP, 16'h0014, RESP_OK);
      rd(ADDR_EXP, 16'h0004, RESP_OK);
      i_link.set_fault(1'b1);
      rd(ADDR_EXP, 16'h0014, RESP_OK);
      rd(ADDR_EXP, 16'h0014, RESP_OK);
      i_link.set_fault(1'b0);
      rd(ADDR_EXP, 16'h0014, RESP_OK);
      rd(ADDR_EXP, 16'h0004, RESP_OK);
      $display("test fault done");
   endtask : t_fault

   task automatic t_flp();
      i_link.flp_burst();
      rd(ADDR_EXP, 16'h0005, RESP_OK);
      rd(ADDR_EXP, 16'h0005, RESP_OK);
      $display("test partner able done");
   endtask : t_flp

   task automatic t_irq();
      wr(ADDR_IRQ_CLR, 16'h0007, RESP_OK);
      rd(ADDR_IRQ_STS, 16'h0000, RESP_OK);
      wr(ADDR_IRQ_EN, 16'h0002, RESP_OK);
      rd(ADDR_IRQ_EN, 16'h0002, RESP_OK);
      i_link.send_word(16'h0001);
      repeat (3) @(posedge mclk);
      `CHK(irq, 1'b1, "irq raised")
      rd(ADDR_IRQ_STS, 16'h0002, RESP_OK);
      wr(ADDR_IRQ_EN, 16'h0000, RESP_OK);
      repeat (3) @(posedge mclk);
      `CHK(irq, 1'b0, "irq masked")
      wr(ADDR_IRQ_EN, 16'h0002, RESP_OK);
      repeat (3) @(posedge mclk);
      `CHK(irq, 1'b1, "irq unmasked")
      wr(ADDR_IRQ_CLR, 16'h0002, RESP_OK);
      repeat (3) @(posedge mclk);
      `CHK(irq, 1'b0, "irq cleared")
      rd(ADDR_IRQ_CLR, 16'h0000, RESP_OK);
      // Unmapped place refuses both ways
      wr(8'hfc, 16'h1234, RESP_ERR);
      rd(8'hfc, 16'h0000, RESP_ERR);
      $display("test irq and bus done");
   endtask : t_irq

   // ==========================================================================
   // Verdict
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // Main sequence
   initial
   begin
      mclk    = 1'b0;
      sys_rst = 1'b1;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      arvalid = 1'b0;
      rready  = 1'b0;
      awaddr  = 8'h00;
      araddr  = 8'h00;
      wdata   = 32'h0000_0000;
      wstrb   = 4'hf;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHK(irq, 1'b0, "irq after reset")
      rd(ADDR_EXP, 16'h0004, RESP_OK);
      t_reserved();
      t_page();
      t_fault();
      t_flp();
      t_irq();
      conclude();
   end
endmodule : aexp_top_bench
